//--- shared/field_policy_params.svh
/*
 Timing-free constants for the register field library.
 Assumes inclusion by bare name from any design or bench file.
*/
`ifndef FIELD_POLICY_PARAMS_SVH
`define FIELD_POLICY_PARAMS_SVH

`define WORD_BITS          32
`define WORD_ADDR_LSBS     2
`define FIELD_RESET_VALUE  32'h0000_0000
`define RESERVED_ONE_BIT   1'b1
`define RESERVED_ZERO_BIT  1'b0

`endif

//--- shared/field_policy_pkg.sv
/*
 Types for the register field library: access policies and the
 packed carriers for a field's write request and hardware event.
 Assumes field_policy_params.svh is on the include path.
*/
`include "field_policy_params.svh"

package field_policy_pkg;

	typedef enum logic [3:0] {
		ordinary_field            = 4'h0,
		reserved_as_one_field     = 4'h1,
		reserved_as_zero_field    = 4'h2,
		should_write_ones_field   = 4'h3,
		preserve_or_ones_field    = 4'h4,
		should_write_zeros_field  = 4'h5,
		preserve_or_zeros_field   = 4'h6,
		write_one_to_clear_bit    = 4'h7,
		writes_ignored_field      = 4'h8,
		reads_zero_ignores_writes = 4'h9,
		reads_one_ignores_writes  = 4'hA,
		hardwired_one_field       = 4'hB,
		hardwired_zero_field      = 4'hC
	} field_policy_t;

	typedef struct packed {
		logic                    direct_write;
		logic                    indirect_write;
		logic [`WORD_BITS-1:0]   data;
	} field_write_t;

	typedef struct packed {
		logic                    set;
		logic [`WORD_BITS-1:0]   mask;
	} field_event_t;

endpackage

//--- hdl/field_cell.sv
/*
 One register field with a parameter-selected access policy.
 Assumes the containing bank decodes addresses and slices words.
*/
`timescale 1ns/1ps

module field_cell
	import field_policy_pkg::*;
#(
	parameter field_policy_t      POLICY     = ordinary_field,
	parameter int                 WIDTH      = 1,
	parameter logic [WIDTH-1:0]   RESET_VAL  = '0
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               wr_direct,
	input  wire logic               wr_indirect,
	input  wire logic [WIDTH-1:0]   wr_data,
	input  wire logic               reserved_ctx,
	input  wire logic [WIDTH-1:0]   hw_set,
	output logic      [WIDTH-1:0]   rd_data,
	output logic      [WIDTH-1:0]   func_value
);

	function automatic logic is_hardwired(input field_policy_t p);
		return p == reads_zero_ignores_writes ||
			p == reads_one_ignores_writes ||
			p == hardwired_one_field ||
			p == hardwired_zero_field;
	endfunction

	function automatic logic ignores_writes(input field_policy_t p);
		return p == should_write_ones_field ||
			p == preserve_or_ones_field ||
			p == should_write_zeros_field ||
			p == preserve_or_zeros_field ||
			p == writes_ignored_field;
	endfunction

	generate
		if (is_hardwired(POLICY)) begin : g_const
			// No storage for hardwired fields
			always_comb begin
				if (POLICY == reads_one_ignores_writes ||
					POLICY == hardwired_one_field)
					rd_data = '1;
				else
					rd_data = '0;
				func_value = rd_data;
			end
		end else begin : g_store
			logic [WIDTH-1:0] value;
			logic [WIDTH-1:0] next_value;

			always_comb begin
				next_value = value;
				if (ignores_writes(POLICY)) begin
					next_value = value;
				end else if (POLICY == write_one_to_clear_bit) begin
					if (wr_direct)
						next_value = value & ~wr_data;
				end else if (POLICY == reserved_as_one_field &&
					wr_indirect && reserved_ctx) begin
					next_value = '1;
				end else if (POLICY == reserved_as_zero_field &&
					wr_indirect && reserved_ctx) begin
					next_value = '0;
				end else if (wr_direct || wr_indirect) begin
					next_value = wr_data;
				end
				// Hardware set wins over a same-cycle clear
				if (POLICY == write_one_to_clear_bit)
					next_value = next_value | hw_set;
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					value <= RESET_VAL;
				else
					value <= next_value;
			end

			always_comb begin
				rd_data = value;
				func_value = value;
				if ((POLICY == reserved_as_one_field ||
					POLICY == reserved_as_zero_field) && reserved_ctx)
					func_value = '0;
				else if (POLICY == should_write_ones_field ||
					POLICY == preserve_or_ones_field ||
					POLICY == should_write_zeros_field ||
					POLICY == preserve_or_zeros_field)
					func_value = '0;
			end
		end
	endgenerate

endmodule

//--- hdl/reserved_field_policy.sv
/*
 Example 32-bit register word built from field cells, one per policy in bits 0..12, ordinary above.
 Assumes the containing bank supplies word-aligned access strobes.
*/
`timescale 1ns/1ps

// What this block does
// - Indirect write in reserved context sets reserved-one bit to one
// - Reserved bit reads last written value
// - Unwritten bit reads its reset value
// - Direct write updates the bit's storage
// - Reserved context zeroes functional value, not read-back
// - Read-only reserved-one bit reads as one
// - Reserved fields unknown, written preserve-or-zeros
// - Should-write-ones field ignores writes
// - Should-write-zeros field ignores writes
// - Direct write of one clears; writing zero keeps
// - Writes-ignored field discards every write
// - Indirect write in reserved context sets reserved-zero bit to zero
// - Read-zero/read-one fields are constant, ignore writes

module reserved_field_policy
	import field_policy_pkg::*;
#(
	parameter int WORD_BITS = `WORD_BITS
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   wr_en,
	input  wire logic                   wr_indirect,
	input  wire logic [31:0]            wr_addr,
	input  wire logic [WORD_BITS-1:0]   wr_data,
	input  wire logic                   reserved_ctx,
	input  wire logic [WORD_BITS-1:0]   hw_set,
	output logic      [WORD_BITS-1:0]   rd_data,
	output logic      [WORD_BITS-1:0]   func_value,
	output logic                        misaligned
);

	localparam int NF = 13;
	localparam field_policy_t POL [NF] = '{
		ordinary_field, reserved_as_one_field, reserved_as_zero_field,
		should_write_ones_field, preserve_or_ones_field,
		should_write_zeros_field, preserve_or_zeros_field,
		write_one_to_clear_bit, writes_ignored_field,
		reads_zero_ignores_writes, reads_one_ignores_writes,
		hardwired_one_field, hardwired_zero_field};

	logic aligned;
	logic [WORD_BITS-1:0] rd_word;
	logic [WORD_BITS-1:0] fn_word;
	logic [WORD_BITS-1:0] next_rd;
	logic [WORD_BITS-1:0] next_fn;

	always_comb begin
		aligned = (wr_addr[`WORD_ADDR_LSBS-1:0] == 2'h0);
	end

	// Fields 0..12 one bit each; bits above are ordinary storage
	genvar i;
	generate
		for (i = 0; i < WORD_BITS; i++) begin : g_field
			localparam field_policy_t P =
				(i < NF) ? POL[(i < NF) ? i : 0] : ordinary_field;
			localparam logic RV =
				(P == reserved_as_one_field) ? `RESERVED_ONE_BIT :
				`RESERVED_ZERO_BIT;
			field_cell #(
				.POLICY    (P),
				.WIDTH     (1),
				.RESET_VAL (RV)
			) u_cell (
				.clk          (clk),
				.rst          (rst),
				.wr_direct    (wr_en & ~wr_indirect & aligned),
				.wr_indirect  (wr_en & wr_indirect & aligned),
				.wr_data      (wr_data[i]),
				.reserved_ctx (reserved_ctx),
				.hw_set       (hw_set[i]),
				.rd_data      (rd_word[i]),
				.func_value   (fn_word[i])
			);
		end
	endgenerate

	always_comb begin
		next_rd = rd_word;
		next_fn = fn_word;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data    <= `FIELD_RESET_VALUE;
			func_value <= `FIELD_RESET_VALUE;
			misaligned <= 1'b0;
		end else begin
			rd_data    <= next_rd;
			func_value <= next_fn;
			misaligned <= wr_en & ~aligned;
		end
	end

endmodule

//--- verif/reserved_field_policy_chk.sv
/*
 Port checker for the example field word.
 Assumes binding to reserved_field_policy.
*/
`timescale 1ns/1ps

module reserved_field_policy_chk
	import field_policy_pkg::*;
#(
	parameter int WORD_BITS = 32
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   wr_en,
	input wire logic                   wr_indirect,
	input wire logic [31:0]            wr_addr,
	input wire logic [WORD_BITS-1:0]   wr_data,
	input wire logic                   reserved_ctx,
	input wire logic [WORD_BITS-1:0]   hw_set,
	input wire logic [WORD_BITS-1:0]   rd_data,
	input wire logic [WORD_BITS-1:0]   func_value,
	input wire logic                   misaligned
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic bad = wr_en && wr_addr[1:0] != 2'h0;
	wire logic al = wr_en && wr_addr[1:0] == 2'h0;
	property p_const; !$past(rst) |-> rd_data[12:9] == 4'h6; endproperty
	a_const: assert property (p_const) else $error("constant bits");
	property p_ign; !$past(rst) |-> {rd_data[8], rd_data[6:3]} == 5'h00;
	endproperty
	a_ign: assert property (p_ign) else $error("ignored bits");
	property p_mis; bad |=> misaligned; endproperty
	a_mis: assert property (p_mis) else $error("no misaligned");
	property p_nomis; !bad |=> !misaligned; endproperty
	a_nomis: assert property (p_nomis) else $error("bad flag");
	property p_one; al && wr_indirect && reserved_ctx |-> ##2 rd_data[1];
	endproperty
	a_one: assert property (p_one) else $error("bit1 not one");
	property p_zero; al && wr_indirect && reserved_ctx |-> ##2 !rd_data[2];
	endproperty
	a_zero: assert property (p_zero) else $error("bit2 not zero");
	property p_dir; al && !wr_indirect |-> ##2 {rd_data[31:13], rd_data[2:0]}
		== $past({wr_data[31:13], wr_data[2:0]}, 2); endproperty
	a_dir: assert property (p_dir) else $error("direct write");
	property p_clr; al && !wr_indirect && wr_data[7] && !hw_set[7]
		|-> ##2 !rd_data[7]; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_keep; al && !wr_data[7] && !hw_set[7]
		|-> ##2 $stable(rd_data[7]); endproperty
	a_keep: assert property (p_keep) else $error("bit7 moved");
	property p_func; reserved_ctx && $past(reserved_ctx)
		|-> func_value[2:1] == 2'h0; endproperty
	a_func: assert property (p_func) else $error("func leak");
endmodule

bind reserved_field_policy reserved_field_policy_chk #(
	.WORD_BITS(WORD_BITS)
) chk (.clk, .rst, .wr_en, .wr_indirect, .wr_addr, .wr_data,
	.reserved_ctx, .hw_set, .rd_data, .func_value, .misaligned);

//--- verif/reserved_field_policy_bench.sv
/*
 Self-checking bench for the example field word.
 Assumes design and checker files are compiled first.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end

module reserved_field_policy_bench;
	import field_policy_pkg::*;
	logic          clk = 0, rst = 1, wr_en = 0, wr_indirect = 0;
	logic          reserved_ctx = 0, misaligned;
	logic [31:0]   wr_addr = '0, wr_data = '0, hw_set = '0;
	logic [31:0]   rd_data, func_value;
	int            bad_count = 0, compares = 0;
	logic [31:0]   rows [3][2] = '{'{32'hFFFFFFFF, 32'hFFFFEC07},
		'{32'h00000000, 32'h00000C00}, '{32'hA5A5A5A5, 32'hA5A5AC05}};

	reserved_field_policy uut (.clk(clk), .rst(rst), .wr_en(wr_en),
		.wr_indirect(wr_indirect), .wr_addr(wr_addr), .wr_data(wr_data),
		.reserved_ctx(reserved_ctx), .hw_set(hw_set), .rd_data(rd_data),
		.func_value(func_value), .misaligned(misaligned));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic wr(input logic ind, input logic [31:0] a, d);
		wr_en = 1; wr_indirect = ind; wr_addr = a; wr_data = d;
		@(posedge clk); #1 wr_en = 0;
		@(posedge clk); #1;
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#100000 bad_count++;
		end_of_test;
	end

	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 0;
		@(posedge clk); #1;
		`CHK("reset", 32'h00000C02, rd_data)
		foreach (rows[i]) begin
			wr(0, 32'h0, rows[i][0]);
			`CHK("row", rows[i][1], rd_data)
		end
		$display("test rows done");
		hw_set = 32'h00000080;
		@(posedge clk); #1 hw_set = '0;
		@(posedge clk); #1;
		`CHK("set", 1'b1, rd_data[7])
		wr(0, 32'h0, 32'h0);
		`CHK("keep", 1'b1, rd_data[7])
		wr(0, 32'h0, 32'h80);
		`CHK("clear", 1'b0, rd_data[7])
		$display("test clear done");
		reserved_ctx = 1;
		wr(1, 32'h0, 32'h0);
		`CHK("ind one", 1'b1, rd_data[1])
		wr(0, 32'h0, 32'h4);
		`CHK("direct", 2'h2, rd_data[2:1])
		`CHK("func", 2'h0, func_value[2:1])
		wr(1, 32'h0, 32'hFFFFFFFF);
		`CHK("ind zero", 2'h1, rd_data[2:1])
		reserved_ctx = 0;
		$display("test context done");
		wr(0, 32'h0, 32'h0);
		wr_en = 1; wr_addr = 32'h2; wr_data = '1;
		@(posedge clk); #1 wr_en = 0;
		`CHK("misaligned", 1'b1, misaligned)
		@(posedge clk); #1;
		`CHK("refused", 32'h00000C00, rd_data)
		$display("test align done");
		rst = 1;
		@(posedge clk); #1;
		`CHK("in reset", 32'h0, rd_data | func_value)
		rst = 0;
		@(posedge clk); #1;
		`CHK("reset", 32'h00000C02, rd_data)
		$display("test reset done");
		end_of_test;
	end
endmodule
